// >>> logic/rtp_pkg.sv
// package for the reload timer: register map, field layout, reset values, modes
// assumes a 32-bit APB slave decoding word-aligned byte offsets
package rtp_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTL0 = 8'h00;
  localparam logic [7:0] ADDR_CTL1 = 8'h04;
  localparam logic [7:0] ADDR_CNTH = 8'h08;
  localparam logic [7:0] ADDR_CNTL = 8'h0C;
  localparam logic [7:0] ADDR_RLDH = 8'h10;
  localparam logic [7:0] ADDR_RLDL = 8'h14;
  localparam logic [7:0] ADDR_PWMH = 8'h18;
  localparam logic [7:0] ADDR_PWML = 8'h1C;
  localparam logic [7:0] ADDR_DEAD = 8'h20;

  // ----------------------------------------
  // control 0 field layout
  // ----------------------------------------
  localparam int EN_BIT = 7;
  localparam int POL_BIT = 6;
  localparam int PRES_LSB = 3;
  localparam int MODE_LSB = 0;

  // ----------------------------------------
  // control 1 field layout
  // ----------------------------------------
  localparam int ISRC_LSB = 0;
  localparam int CAPF_BIT = 2;

  // ----------------------------------------
  // reset and restart values
  // ----------------------------------------
  localparam logic [15:0] CNT_RESTART = 16'h0001;
  localparam logic [15:0] CNT_RESET = 16'h0001;
  localparam logic [15:0] RLD_RESET = 16'hFFFF;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [2:0] {
    RTP_MODE_CONT = 3'b000,
    RTP_MODE_PWM = 3'b001,
    RTP_MODE_CAPT = 3'b010,
    RTP_MODE_GATED = 3'b011,
    RTP_MODE_CAPCMP = 3'b100,
    RTP_MODE_DUAL = 3'b101
  } rtp_mode_type;

  // interrupt source select: both, input event only, reload only
  typedef enum logic [1:0] {
    RTP_ISRC_BOTH = 2'b00,
    RTP_ISRC_INPUT = 2'b10,
    RTP_ISRC_RELOAD = 2'b11
  } rtp_isrc_type;

endpackage : rtp_pkg

// >>> logic/rtp_timer.sv
// reload timer with prescaler, pwm, dual pwm, capture, gated and capture/compare
// assumes an APB master on pclk; timer input pin is asynchronous to pclk
`timescale 1ns/10ps

// How it works
// - prescaler divides clock by 1 to 128
// - pwm restarts from 0001H after reset
// - dual pwm turns input pin into output
// - pwm period is reload times prescale
// - polarity picks which phase is high
// - capture copies count into pwm registers
// - gated restarts from 0001H after reset
// - gated interrupts on deassertion and/or reload
// - gated counts while input asserted
// - capcmp starts on first edge, no interrupt
// - later edge captures, flags, restarts count
// - compare match interrupts, clears flag, restarts
// - capcmp interrupt source selectable
// - high byte read latches low byte
// - disabled low read returns live count
// - output toggles on every reload outside pwm and dual pwm
module rtp_timer #(
  parameter int PRES_BITS = 3
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer pins
  input wire logic timer_in,
  output logic timer_out,
  output logic timer_out_n,
  output logic timer_out_n_oe,
  output logic timer_irq
);

  if (PRES_BITS != 3) begin : g_bad_pres
    $error("prescale field must be 3 bits");
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] ctl0;
  logic [1:0] isrc;
  logic capture_cause_flag;
  logic [15:0] count;
  logic [15:0] reload;
  logic [15:0] pwm_val;
  logic [7:0] dead;
  logic [7:0] hold_low;
  logic [6:0] pres_cnt;
  logic armed;
  logic in_s1, in_s2, in_s3;
  logic out_lvl;
  logic [7:0] dead_cnt;

  wire enabled = ctl0[rtp_pkg::EN_BIT];
  wire timer_polarity_bit = ctl0[rtp_pkg::POL_BIT];
  wire [PRES_BITS-1:0] pres_sel = ctl0[rtp_pkg::PRES_LSB +: PRES_BITS];
  wire [2:0] mode = ctl0[rtp_pkg::MODE_LSB +: 3];

  wire is_pwm = (mode == rtp_pkg::RTP_MODE_PWM) || (mode == rtp_pkg::RTP_MODE_DUAL);
  wire is_capt = (mode == rtp_pkg::RTP_MODE_CAPT);
  wire is_gated = (mode == rtp_pkg::RTP_MODE_GATED);
  wire is_capcmp = (mode == rtp_pkg::RTP_MODE_CAPCMP);
  wire is_dual = (mode == rtp_pkg::RTP_MODE_DUAL);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire acc = psel && penable && clk_en;
  wire wr = acc && pwrite;
  // read strobe at the setup edge, where prdata is taken, so both halves share one count
  wire rd = psel && !penable && !pwrite && clk_en;
  wire wr_ctl0 = wr && (paddr == rtp_pkg::ADDR_CTL0);
  wire wr_ctl1 = wr && (paddr == rtp_pkg::ADDR_CTL1);
  wire wr_cnth = wr && (paddr == rtp_pkg::ADDR_CNTH);
  wire wr_cntl = wr && (paddr == rtp_pkg::ADDR_CNTL);
  wire rd_cnth = rd && (paddr == rtp_pkg::ADDR_CNTH);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= rtp_pkg::ADDR_DEAD) && (a[1:0] == 2'b00);
  endfunction : mapped

  logic [31:0] rd_mux;
  always_comb begin
    if (paddr == rtp_pkg::ADDR_CTL0) begin
      rd_mux = {24'h000000, ctl0};
    end else if (paddr == rtp_pkg::ADDR_CTL1) begin
      rd_mux = {29'h0000000, capture_cause_flag, isrc};
    end else if (paddr == rtp_pkg::ADDR_CNTH) begin
      rd_mux = {24'h000000, count[15:8]};
    end else if (paddr == rtp_pkg::ADDR_CNTL) begin
      // latched value while running, live count when stopped
      rd_mux = {24'h000000, enabled ? hold_low : count[7:0]};
    end else if (paddr == rtp_pkg::ADDR_RLDH) begin
      rd_mux = {24'h000000, reload[15:8]};
    end else if (paddr == rtp_pkg::ADDR_RLDL) begin
      rd_mux = {24'h000000, reload[7:0]};
    end else if (paddr == rtp_pkg::ADDR_PWMH) begin
      rd_mux = {24'h000000, pwm_val[15:8]};
    end else if (paddr == rtp_pkg::ADDR_PWML) begin
      rd_mux = {24'h000000, pwm_val[7:0]};
    end else if (paddr == rtp_pkg::ADDR_DEAD) begin
      rd_mux = {24'h000000, dead};
    end else begin
      rd_mux = rtp_pkg::RD_UNMAPPED;
    end
  end

  // ----------------------------------------
  // input synchroniser and edge detect
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1 <= 1'b0;
      in_s2 <= 1'b0;
      in_s3 <= 1'b0;
    end else if (clk_en) begin
      in_s1 <= timer_in;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
    end
  end

  // pin is an output in dual pwm, so its edges are ignored there
  wire in_lvl = in_s2 && !is_dual;
  wire in_prev = in_s3 && !is_dual;
  wire rise = in_lvl && !in_prev;
  wire fall = !in_lvl && in_prev;
  wire sel_edge = timer_polarity_bit ? fall : rise;
  wire in_active = timer_polarity_bit ? !in_lvl : in_lvl;
  wire gate_deassert = timer_polarity_bit ? rise : fall;

  // ----------------------------------------
  // prescaler and count control
  // ----------------------------------------
  wire [6:0] pres_max = 7'((8'h01 << pres_sel) - 8'h01);
  wire tick = (pres_cnt == pres_max);
  wire gate_ok = !is_gated || in_active;
  wire wait_ok = !is_capcmp || armed;
  wire run = enabled && gate_ok && wait_ok;
  wire hit = (count == reload);
  wire reload_ev = run && tick && hit;
  wire cap_ev = enabled && armed && (is_capcmp || is_capt) && sel_edge;

  // interrupt source selection
  wire src_in_ok = (isrc != rtp_pkg::RTP_ISRC_RELOAD);
  wire src_rl_ok = (isrc != rtp_pkg::RTP_ISRC_INPUT);
  wire in_irq_ev = (cap_ev && is_capcmp) || (enabled && is_gated && gate_deassert);
  wire next_irq = (in_irq_ev && src_in_ok) || (reload_ev && src_rl_ok);

  // pwm compare point; polarity picks which phase is high
  wire pwm_phase = (count > pwm_val);
  wire next_pwm = timer_polarity_bit ? !pwm_phase : pwm_phase;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pres_cnt <= 7'h00;
    end else if (clk_en) begin
      pres_cnt <= (!run || tick) ? 7'h00 : pres_cnt + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= rtp_pkg::CNT_RESET;
    end else if (clk_en) begin
      if (wr_cnth) begin
        count[15:8] <= pwdata[7:0];
      end else if (wr_cntl) begin
        count[7:0] <= pwdata[7:0];
      end else if (cap_ev && is_capcmp) begin
        count <= rtp_pkg::CNT_RESTART;
      end else if (reload_ev) begin
        // software start value only held for the first pass
        count <= rtp_pkg::CNT_RESTART;
      end else if (run && tick) begin
        count <= count + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0 <= rtp_pkg::CTL_RESET;
      isrc <= 2'b00;
      reload <= rtp_pkg::RLD_RESET;
      dead <= 8'h00;
    end else if (clk_en) begin
      if (wr_ctl0) ctl0 <= pwdata[7:0];
      if (wr_ctl1) isrc <= pwdata[rtp_pkg::ISRC_LSB +: 2];
      if (wr && paddr == rtp_pkg::ADDR_RLDH) reload[15:8] <= pwdata[7:0];
      if (wr && paddr == rtp_pkg::ADDR_RLDL) reload[7:0] <= pwdata[7:0];
      if (wr && paddr == rtp_pkg::ADDR_DEAD) dead <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_val <= 16'h0000;
    end else if (clk_en) begin
      if (cap_ev) begin
        pwm_val <= count;
      end else if (wr && paddr == rtp_pkg::ADDR_PWMH) begin
        pwm_val[15:8] <= pwdata[7:0];
      end else if (wr && paddr == rtp_pkg::ADDR_PWML) begin
        pwm_val[7:0] <= pwdata[7:0];
      end
    end
  end

  // capture wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_cause_flag <= 1'b0;
    end else if (clk_en) begin
      if (cap_ev && is_capcmp) begin
        capture_cause_flag <= 1'b1;
      end else if (reload_ev && is_capcmp) begin
        capture_cause_flag <= 1'b0;
      end else if (wr_ctl1 && !pwdata[rtp_pkg::CAPF_BIT]) begin
        capture_cause_flag <= 1'b0;
      end
    end
  end

  // armed: first qualifying edge seen in capcmp; always armed elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (clk_en) begin
      if (!enabled || !is_capcmp) begin
        armed <= !is_capcmp;
      end else if (sel_edge) begin
        armed <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_low <= 8'h00;
    end else if (clk_en && rd_cnth && enabled) begin
      hold_low <= count[7:0];
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_lvl <= 1'b0;
      timer_out <= 1'b0;
      timer_out_n <= 1'b0;
      timer_out_n_oe <= 1'b0;
      timer_irq <= 1'b0;
      dead_cnt <= 8'h00;
    end else if (clk_en) begin
      timer_irq <= next_irq;
      timer_out_n_oe <= is_dual;
      if (reload_ev) out_lvl <= !out_lvl;
      if (!is_pwm) begin
        timer_out <= out_lvl ^ reload_ev;
        timer_out_n <= 1'b0;
        dead_cnt <= 8'h00;
      end else if (next_pwm != timer_out || next_pwm == timer_out_n) begin
        // both drives low through the dead band before either turns on
        if (dead_cnt < dead) begin
          dead_cnt <= dead_cnt + 8'h01;
          timer_out <= 1'b0;
          timer_out_n <= 1'b0;
        end else begin
          dead_cnt <= 8'h00;
          timer_out <= next_pwm;
          timer_out_n <= is_dual && !next_pwm;
        end
      end
    end
  end

  // ----------------------------------------
  // apb answer: zero wait states
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      prdata <= (psel && !penable && !pwrite) ? rd_mux : prdata;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && reload_ev && !wr_cnth && !wr_cntl && !(cap_ev && is_capcmp))
      |=> count == rtp_pkg::CNT_RESTART)
    else $error("count did not restart at 0001");
  AST_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && reload_ev) |=> out_lvl != $past(out_lvl))
    else $error("output level did not toggle on reload");
  AST_CAPFLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && cap_ev && is_capcmp) |=> capture_cause_flag && pwm_val == $past(count))
    else $error("capture did not store count or set flag");
  AST_CMPCLR: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && reload_ev && is_capcmp && !cap_ev) |=> !capture_cause_flag)
    else $error("compare did not clear capture flag");
  AST_NOFIRST: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && is_capcmp && !armed) |=> !timer_irq)
    else $error("first edge treated as capture");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && rd_cnth && enabled) |=> hold_low == $past(count[7:0]))
    else $error("low byte not latched on high read");
  AST_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && is_gated && !in_active && !wr_cnth && !wr_cntl) |=> $stable(count))
    else $error("gated counter moved while gate closed");
  AST_DUALOE: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && is_dual) |=> timer_out_n_oe)
    else $error("complement pin not driven in dual pwm");
  AST_PRES: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && run && pres_cnt != pres_max && !wr_cnth && !wr_cntl
      && !(cap_ev && is_capcmp)) |=> $stable(count))
    else $error("count advanced between prescaled ticks");

endmodule : rtp_timer

// >>> dv/rtp_pin_src.sv
// far-side model: signal source on the shared timer pin
// assumes the bench sets want just after pclk edges
`timescale 1ns/10ps
module rtp_pin_src (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench request and device drive
  input wire logic want,
  input wire logic dev_oe,
  input wire logic dev_val,
  // pin
  output logic pin
);
  logic lvl;
  logic [1:0] held;
  // ----------------------------------------
  // level source
  // ----------------------------------------
  // hold of at least three cycles keeps the pin within a third of pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl <= 1'b0;
      held <= 2'h0;
    end else if (want != lvl && held == 2'h2) begin
      lvl <= want;
      held <= 2'h0;
    end else if (held != 2'h2) begin
      held <= held + 2'h1;
    end
  end
  // device owns the pin while its complement output is enabled
  assign pin = dev_oe ? dev_val : lvl;
endmodule : rtp_pin_src

// >>> dv/rtp_timer_tb.sv
// self-checking bench for the reload timer
// assumes APB answers with pready; timer pin comes from rtp_pin_src
`timescale 1ns/10ps
module rtp_timer_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, timer_in, timer_out, timer_out_n, timer_out_n_oe, timer_irq;
  logic want = 1'b0;
  logic clk_en = 1'b1;
  logic slv;
  logic [31:0] q, h;
  int error_cnt = 0;
  int check_count = 0;
  int irq_n = 0;
  int hi, lo, b;
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
  logic [31:0] rv [10] = '{0, 0, 0, 32'h01, 32'hFF, 32'hFF, 0, 0, 0, 0};

  always #25 pclk = ~pclk;
  always @(posedge pclk) if (timer_irq === 1'b1) irq_n++;

  rtp_timer u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_in(timer_in), .timer_out(timer_out),
    .timer_out_n(timer_out_n), .timer_out_n_oe(timer_out_n_oe), .timer_irq(timer_irq));
  rtp_pin_src u_src (.pclk(pclk), .presetn(presetn), .want(want),
    .dev_oe(timer_out_n_oe), .dev_val(timer_out_n), .pin(timer_in));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] cw(input logic en, pol, input logic [2:0] pr, md);
    return {24'h0, en, pol, pr, md};
  endfunction : cw
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", {31'h0, pready}, 32'h1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // whole high and low phases of timer_out, in cycles
  task automatic meas(output int h1, l1);
    int n;
    n = 0;
    while (timer_out !== 1'b0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    while (timer_out !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    h1 = 0;
    l1 = 0;
    while (timer_out === 1'b1 && h1 < 3000) begin
      @(posedge pclk);
      h1++;
    end
    while (timer_out === 1'b0 && l1 < 3000) begin
      @(posedge pclk);
      l1++;
    end
  endtask : meas
  task automatic cfg(input logic [15:0] rl, st, input logic [31:0] c0);
    wr(8'h00, c0 & 32'hFFFF_FF7F);
    wr(8'h10, {24'h0, rl[15:8]});
    wr(8'h14, {24'h0, rl[7:0]});
    wr(8'h08, {24'h0, st[15:8]});
    wr(8'h0C, {24'h0, st[7:0]});
    wr(8'h00, c0);
  endtask : cfg
  task automatic tally_and_finish;
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    cyc(30000);
    error_cnt++;
    tally_and_finish;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(5);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset_rd", q, rv[i]);
      chk("slverr", {31'h0, slv}, {31'h0, ra[i] == 8'h24});
    end
    wr(8'h24, 32'hFF);
    chk("wr_slverr", {31'h0, slv}, 32'h1);
    // continuous: half period is reload times prescale
    foreach (rv[p]) if (p == 0 || p == 3 || p == 7) begin
      cfg(16'h0004, 16'h0001, cw(1'b1, 1'b0, 3'(p), rtp_pkg::RTP_MODE_CONT));
      meas(hi, lo);
      chk("cont_hi", 32'(hi), 32'(4 << p));
      chk("cont_lo", 32'(lo), 32'(4 << p));
    end
    // pwm with a start count of 6: later passes must restart at 1
    wr(8'h18, 32'h0);
    wr(8'h1C, 32'h03);
    for (int pol = 0; pol < 2; pol++) begin
      cfg(16'h0008, 16'h0006, cw(1'b1, 1'(pol), 3'h0, rtp_pkg::RTP_MODE_PWM));
      meas(hi, lo);
      chk("pwm_hi", 32'(hi), pol ? 32'h3 : 32'h5);
      chk("pwm_per", 32'(hi + lo), 32'h8);
      chk("pwm_oe", {31'h0, timer_out_n_oe}, 32'h0);
    end
    cfg(16'h0008, 16'h0001, cw(1'b1, 1'b0, 3'h0, rtp_pkg::RTP_MODE_DUAL));
    cyc(5);
    for (int i = 0; i < 8; i++) begin
      @(negedge pclk);
      chk("dual_oe", {31'h0, timer_out_n_oe}, 32'h1);
      chk("dual_n", {31'h0, timer_out_n}, {31'h0, ~timer_out});
    end
    // dead band of 2: both drives low for 2 cycles at each change, 4 of every 8
    wr(8'h20, 32'h2);
    cyc(16);
    b = 0;
    for (int i = 0; i < 16; i++) begin
      @(negedge pclk);
      if (timer_out === 1'b0 && timer_out_n === 1'b0) b++;
      chk("dual_overlap", {31'h0, timer_out & timer_out_n}, 32'h0);
    end
    chk("dead_band", 32'(b), 32'h8);
    // gated: counter held while input low, high-byte read latches low byte
    cfg(16'hFFFF, 16'h1234, cw(1'b0, 1'b0, 3'h0, rtp_pkg::RTP_MODE_GATED));
    apb(1'b0, 8'h0C, 32'h0);
    chk("live_lo", q, 32'h34);
    wr(8'h00, cw(1'b1, 1'b0, 3'h0, rtp_pkg::RTP_MODE_GATED));
    cyc(10);
    apb(1'b0, 8'h08, 32'h0);
    chk("gate_hold", q, 32'h12);
    b = irq_n;
    want <= 1'b1;
    cyc(40);
    want <= 1'b0;
    cyc(10);
    chk("gate_irq", 32'(irq_n - b), 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk("latch_lo", q, 32'h34);
    apb(1'b0, 8'h08, 32'h0);
    h = q;
    apb(1'b0, 8'h0C, 32'h0);
    hi = int'({h[7:0], q[7:0]}) - 32'h1234;
    chk("gate_cnt", {31'h0, hi >= 35 && hi <= 45}, 32'h1);
    // capture/compare
    wr(8'h04, 32'h0);
    cfg(16'h0100, 16'h0001, cw(1'b1, 1'b0, 3'h0, rtp_pkg::RTP_MODE_CAPCMP));
    b = irq_n;
    want <= 1'b1;
    cyc(20);
    chk("first_edge", 32'(irq_n - b), 32'h0);
    want <= 1'b0;
    cyc(10);
    want <= 1'b1;
    cyc(10);
    chk("cap_irq", 32'(irq_n - b), 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("cap_flag", q & 32'h4, 32'h4);
    apb(1'b0, 8'h1C, 32'h0);
    chk("cap_val", {31'h0, q >= 26 && q <= 36}, 32'h1);
    cyc(300);
    chk("cmp_irq", 32'(irq_n - b), 32'h2);
    apb(1'b0, 8'h04, 32'h0);
    chk("cmp_flag", q & 32'h4, 32'h0);
    wr(8'h04, 32'h3);
    b = irq_n;
    want <= 1'b0;
    cyc(10);
    want <= 1'b1;
    cyc(10);
    chk("src_reload", 32'(irq_n - b), 32'h0);
    cyc(300);
    chk("src_cmp", 32'(irq_n - b), 32'h1);
    wr(8'h04, 32'h2);
    b = irq_n;
    want <= 1'b0;
    cyc(10);
    want <= 1'b1;
    cyc(10);
    chk("src_input", 32'(irq_n - b), 32'h1);
    cyc(300);
    chk("src_nocmp", 32'(irq_n - b), 32'h1);
    // capture mode on falling edges: a rise must not capture
    cfg(16'hFFFF, 16'h0001, cw(1'b1, 1'b1, 3'h0, rtp_pkg::RTP_MODE_CAPT));
    cyc(5);
    want <= 1'b0;
    cyc(10);
    apb(1'b0, 8'h1C, 32'h0);
    chk("capt_fall", {31'h0, q >= 6 && q <= 12}, 32'h1);
    want <= 1'b1;
    cyc(20);
    apb(1'b0, 8'h1C, 32'h0);
    chk("capt_rise", {31'h0, q >= 6 && q <= 12}, 32'h1);
    // clock enable low for 50 cycles: only the enabled cycles count
    cfg(16'hFFFF, 16'h0001, cw(1'b1, 1'b0, 3'h0, rtp_pkg::RTP_MODE_CONT));
    apb(1'b0, 8'h08, 32'h0);
    h = q;
    apb(1'b0, 8'h0C, 32'h0);
    lo = int'({h[7:0], q[7:0]});
    clk_en <= 1'b0;
    cyc(50);
    clk_en <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    h = q;
    apb(1'b0, 8'h0C, 32'h0);
    hi = int'({h[7:0], q[7:0]}) - lo;
    chk("freeze", {31'h0, hi >= 4 && hi <= 8}, 32'h1);
    // second reset in mid-run
    presetn <= 1'b0;
    cyc(2);
    chk("rst_out", {27'h0, pready, timer_out, timer_out_n, timer_out_n_oe, timer_irq}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("rst_ctl", q, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("rst_rld", q, 32'hFF);
    tally_and_finish;
  end
endmodule : rtp_timer_tb
